// [verilog/clk_out_cfg_pkg.sv]
package clk_out_cfg_pkg;

  // Register offsets on the serial control port
  localparam logic [7:0] ADDR_FORMAT_SLEEP = 8'h06;
  localparam logic [7:0] ADDR_OFFSET_REF = 8'h07;
  localparam logic [7:0] ADDR_STATIC_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_HISTORY_AVG_TIME = 8'h09;
  localparam logic [7:0] ADDR_BUF_PD = 8'h0a;

  // Reset values
  localparam logic [7:0] RST_FORMAT_SLEEP = 8'h2d;
  localparam logic [7:0] RST_OFFSET_REF = 8'h2a;
  localparam logic [7:0] RST_STATIC_LEVEL = 8'h00;
  localparam logic [7:0] RST_HISTORY_AVG_TIME = 8'hc0;
  localparam logic [7:0] RST_BUF_PD = 8'h00;

  // Field positions
  localparam int SLEEP_BIT = 6;
  localparam int OUT2_FMT_LSB = 3;
  localparam int OUT1_FMT_LSB = 0;
  localparam int OFFSET_REF_LSB = 0;
  localparam int OUT2_HOLD_LSB = 6;
  localparam int OUT1_HOLD_LSB = 4;
  localparam int HISTORY_AVG_TIME_LSB = 3;
  localparam int OUT2_PD_BIT = 3;
  localparam int OUT1_PD_BIT = 2;

  // Writable bit masks; all other bits are reserved and keep their reset value
  localparam logic [7:0] WMASK_FORMAT_SLEEP = 8'h7f;
  localparam logic [7:0] WMASK_OFFSET_REF = 8'h07;
  localparam logic [7:0] WMASK_STATIC_LEVEL = 8'hf0;
  localparam logic [7:0] WMASK_HISTORY_AVG_TIME = 8'hf8;
  localparam logic [7:0] WMASK_BUF_PD = 8'h0c;

  // Format field codes
  localparam logic [2:0] FMT_CODE_DISABLE = 3'h1;
  localparam logic [2:0] FMT_CODE_CMOS = 3'h2;
  localparam logic [2:0] FMT_CODE_LVDS_LOW = 3'h3;
  localparam logic [2:0] FMT_CODE_LVPECL = 3'h5;
  localparam logic [2:0] FMT_CODE_CML = 3'h6;
  localparam logic [2:0] FMT_CODE_LVDS = 3'h7;

  // Offset alarm reference codes
  localparam logic [2:0] REF_CODE_CRYSTAL = 3'h0;
  localparam logic [2:0] REF_CODE_INPUT_1 = 3'h1;
  localparam logic [2:0] REF_CODE_INPUT_2 = 3'h2;

  // Static hold codes
  localparam logic [1:0] HOLD_CODE_NORMAL = 2'h0;
  localparam logic [1:0] HOLD_CODE_LOW = 2'h1;
  localparam logic [1:0] HOLD_CODE_HIGH = 2'h2;

  typedef enum logic [2:0] {
    FMT_OFF,
    FMT_CMOS,
    FMT_LVDS_LOW,
    FMT_LVPECL,
    FMT_CML,
    FMT_LVDS
  } out_format_t;

  typedef enum logic [1:0] {
    REF_NONE,
    REF_CRYSTAL,
    REF_INPUT_1,
    REF_INPUT_2
  } offset_ref_t;

  typedef enum logic [1:0] {
    HOLD_NONE,
    HOLD_LOW,
    HOLD_HIGH
  } hold_state_t;

  // Per-output buffer controls
  typedef struct packed {
    logic buffer_on;
    out_format_t format;
    logic divider_power_down;
  } out_ctrl_t;

endpackage

// [verilog/clock_output_config_regs.sv]
// Summary of operation
// - Sleep set disables all outputs and powers down circuitry, overriding both formats.
// - Output 2 format: 001 off, 010 CMOS, 011 low LVDS, 101 LVPECL, 110 CML, 111 LVDS.
// - Output 1 format: same codes without CML; 000 and 100 reserved.
// - Offset alarm reference: 000 crystal, 001 input 1, 010 input 2, others reserved.
// - Output 2 static hold: 00 toggle, 01 hold low, 10 hold high.
// - Output 1 static hold: 00 toggle, 01 hold low, 10 hold high.
// - Entering or leaving static hold produces no glitch or runt pulse.
// - Five-bit averaging field sets history averaging time for digital hold.
// - Output 2 disable bit powers down its buffer and low-speed divider.
// - Output 1 disable bit powers down its buffer and low-speed divider.
// - Reset values: 0x2d, 0x2a, 0x00, 0xc0, 0x00.
// - Forced digital hold overrides all input selection and ignores input quality.
module clock_output_config_regs
  import clk_out_cfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [1:0] i_raw_clock_output,
  input wire logic i_force_digital_hold,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_sleep,
  output out_ctrl_t o_out1_ctrl,
  output out_ctrl_t o_out2_ctrl,
  output logic o_clock_output_1,
  output logic o_clock_output_2,
  output offset_ref_t o_offset_alarm_ref_sel,
  output logic [4:0] o_history_avg_time,
  output logic o_digital_hold_active
);

  // Format decode shared by both outputs; reserved codes fall back to off
  function automatic out_format_t decode_format(input logic [2:0] code, input logic cml_ok);
    out_format_t f;
    f = FMT_OFF;
    case (code)
      FMT_CODE_CMOS: f = FMT_CMOS;
      FMT_CODE_LVDS_LOW: f = FMT_LVDS_LOW;
      FMT_CODE_LVPECL: f = FMT_LVPECL;
      FMT_CODE_CML: f = cml_ok ? FMT_CML : FMT_OFF;
      FMT_CODE_LVDS: f = FMT_LVDS;
      default: f = FMT_OFF;
    endcase
    return f;
  endfunction

  // Masked write; reserved bits always re-take the reset value
  function automatic logic [7:0] masked_write(input logic [7:0] wdata,
                                              input logic [7:0] mask,
                                              input logic [7:0] rst);
    return (wdata & mask) | (rst & ~mask);
  endfunction

  logic [7:0] fmt_sleep_q, fmt_sleep_d;
  logic [7:0] offset_ref_q, offset_ref_d;
  logic [7:0] static_level_q, static_level_d;
  logic [7:0] history_avg_time_q, history_avg_time_d;
  logic [7:0] buf_pd_q, buf_pd_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Register file: writes and read-back
  always_comb begin
    fmt_sleep_d = fmt_sleep_q;
    offset_ref_d = offset_ref_q;
    static_level_d = static_level_q;
    history_avg_time_d = history_avg_time_q;
    buf_pd_d = buf_pd_q;
    rvalid_d = i_reg_rd;
    rdata_d = rdata_q;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_FORMAT_SLEEP: fmt_sleep_d =
          masked_write(i_reg_wdata, WMASK_FORMAT_SLEEP, RST_FORMAT_SLEEP);
        ADDR_OFFSET_REF: offset_ref_d =
          masked_write(i_reg_wdata, WMASK_OFFSET_REF, RST_OFFSET_REF);
        ADDR_STATIC_LEVEL: static_level_d =
          masked_write(i_reg_wdata, WMASK_STATIC_LEVEL, RST_STATIC_LEVEL);
        ADDR_HISTORY_AVG_TIME: history_avg_time_d =
          masked_write(i_reg_wdata, WMASK_HISTORY_AVG_TIME, RST_HISTORY_AVG_TIME);
        ADDR_BUF_PD: buf_pd_d =
          masked_write(i_reg_wdata, WMASK_BUF_PD, RST_BUF_PD);
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_FORMAT_SLEEP: rdata_d = fmt_sleep_q;
        ADDR_OFFSET_REF: rdata_d = offset_ref_q;
        ADDR_STATIC_LEVEL: rdata_d = static_level_q;
        ADDR_HISTORY_AVG_TIME: rdata_d = history_avg_time_q;
        ADDR_BUF_PD: rdata_d = buf_pd_q;
        default: rdata_d = 8'h00; // Unmapped addresses read zero
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      fmt_sleep_q <= RST_FORMAT_SLEEP;
      offset_ref_q <= RST_OFFSET_REF;
      static_level_q <= RST_STATIC_LEVEL;
      history_avg_time_q <= RST_HISTORY_AVG_TIME;
      buf_pd_q <= RST_BUF_PD;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      fmt_sleep_q <= fmt_sleep_d;
      offset_ref_q <= offset_ref_d;
      static_level_q <= static_level_d;
      history_avg_time_q <= history_avg_time_d;
      buf_pd_q <= buf_pd_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Field extraction
  logic sleep_w;
  logic [2:0] fmt_code_w [2];
  logic [1:0] hold_code_w [2];
  logic pd_w [2];
  assign sleep_w = fmt_sleep_q[SLEEP_BIT];
  assign fmt_code_w[0] = fmt_sleep_q[OUT1_FMT_LSB +: 3];
  assign fmt_code_w[1] = fmt_sleep_q[OUT2_FMT_LSB +: 3];
  assign hold_code_w[0] = static_level_q[OUT1_HOLD_LSB +: 2];
  assign hold_code_w[1] = static_level_q[OUT2_HOLD_LSB +: 2];
  assign pd_w[0] = buf_pd_q[OUT1_PD_BIT];
  assign pd_w[1] = buf_pd_q[OUT2_PD_BIT];

  out_ctrl_t ctrl_q [2];
  out_ctrl_t ctrl_d [2];
  hold_state_t hold_q [2];
  hold_state_t hold_d [2];
  logic clk_out_q [2];
  logic clk_out_d [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      hold_state_t want;
      logic hold_level;
      // Buffer controls and glitch-free static hold for one output
      always_comb begin
        want = HOLD_NONE;
        hold_level = 1'b0;
        ctrl_d[g].format = decode_format(fmt_code_w[g], g == 1);
        ctrl_d[g].buffer_on = !sleep_w && !pd_w[g] &&
                              (ctrl_d[g].format != FMT_OFF);
        ctrl_d[g].divider_power_down = sleep_w || pd_w[g];
        if (sleep_w || pd_w[g]) begin
          ctrl_d[g].format = FMT_OFF;
        end
        case (hold_code_w[g])
          HOLD_CODE_LOW: want = HOLD_LOW;
          HOLD_CODE_HIGH: want = HOLD_HIGH;
          default: want = HOLD_NONE; // Reserved 11 keeps toggling
        endcase
        // Switch only while the raw clock already sits at the held level, so
        // no edge is cut short; a low-to-high change passes through toggling
        hold_d[g] = hold_q[g];
        if (hold_q[g] != HOLD_NONE && hold_q[g] != want) begin
          if (i_raw_clock_output[g] == (hold_q[g] == HOLD_HIGH)) begin
            hold_d[g] = HOLD_NONE;
          end
        end else if (hold_q[g] == HOLD_NONE && want != HOLD_NONE) begin
          if (i_raw_clock_output[g] == (want == HOLD_HIGH)) begin
            hold_d[g] = want;
          end
        end
        hold_level = (hold_d[g] == HOLD_HIGH);
        if (!ctrl_d[g].buffer_on) begin
          clk_out_d[g] = 1'b0;
        end else if (hold_d[g] != HOLD_NONE) begin
          clk_out_d[g] = hold_level;
        end else begin
          clk_out_d[g] = i_raw_clock_output[g];
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
          ctrl_q[g] <= '{buffer_on: 1'b0, format: FMT_OFF, divider_power_down: 1'b1};
          hold_q[g] <= HOLD_NONE;
          clk_out_q[g] <= 1'b0;
        end else begin
          ctrl_q[g] <= ctrl_d[g];
          hold_q[g] <= hold_d[g];
          clk_out_q[g] <= clk_out_d[g];
        end
      end
    end
  endgenerate

  offset_ref_t ref_q, ref_d;
  logic sleep_q, sleep_d;
  logic force_digital_hold_q, force_digital_hold_d;
  logic [4:0] avg_q, avg_d;

  // Alarm reference, averaging time and forced hold status
  always_comb begin
    case (offset_ref_q[OFFSET_REF_LSB +: 3])
      REF_CODE_CRYSTAL: ref_d = REF_CRYSTAL;
      REF_CODE_INPUT_1: ref_d = REF_INPUT_1;
      REF_CODE_INPUT_2: ref_d = REF_INPUT_2;
      default: ref_d = REF_NONE; // Reserved codes select no reference
    endcase
    sleep_d = sleep_w;
    avg_d = history_avg_time_q[HISTORY_AVG_TIME_LSB +: 5];
    force_digital_hold_d = i_force_digital_hold; // Overrides any input quality
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ref_q <= REF_INPUT_2;
      sleep_q <= 1'b0;
      avg_q <= RST_HISTORY_AVG_TIME[HISTORY_AVG_TIME_LSB +: 5];
      force_digital_hold_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      sleep_q <= sleep_d;
      avg_q <= avg_d;
      force_digital_hold_q <= force_digital_hold_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_sleep = sleep_q;
  assign o_out1_ctrl = ctrl_q[0];
  assign o_out2_ctrl = ctrl_q[1];
  assign o_clock_output_1 = clk_out_q[0];
  assign o_clock_output_2 = clk_out_q[1];
  assign o_offset_alarm_ref_sel = ref_q;
  assign o_history_avg_time = avg_q;
  assign o_digital_hold_active = force_digital_hold_q;

endmodule

// [verification/clock_output_config_regs_asserts.sv]
module clock_output_config_regs_asserts
  import clk_out_cfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_force_digital_hold,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_sleep,
  input wire out_ctrl_t o_out1_ctrl,
  input wire out_ctrl_t o_out2_ctrl,
  input wire logic o_clock_output_1,
  input wire logic [4:0] o_history_avg_time,
  input wire logic o_digital_hold_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // Register port answers
  rvalid_lag_a: assert property ($past(i_nrst) |-> o_reg_rvalid == $past(i_reg_rd))
    else $error("rvalid not one cycle after read");
  rdata_hold_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("rdata moved without a read");
  // Sleep write reaches the outputs two edges after the strobe
  sleep_write_a: assert property (i_reg_wr && i_reg_addr == ADDR_FORMAT_SLEEP |->
    ##2 o_sleep == $past(i_reg_wdata[SLEEP_BIT], 2)) else $error("sleep not taken");
  sleep_off_a: assert property (o_sleep |-> !o_out1_ctrl.buffer_on &&
    !o_out2_ctrl.buffer_on && o_out1_ctrl.divider_power_down && o_out2_ctrl.divider_power_down)
    else $error("sleep left a buffer on");
  // Divider power down always comes with the buffer off
  pd_buffer_a: assert property ((!o_out1_ctrl.divider_power_down || !o_out1_ctrl.buffer_on) &&
    (!o_out2_ctrl.divider_power_down || !o_out2_ctrl.buffer_on)) else $error("divider off, buffer on");
  off_zero_a: assert property (!o_out1_ctrl.buffer_on && !$past(o_out1_ctrl.buffer_on) |->
    !o_clock_output_1) else $error("disabled output toggles");
  // The command may stand high through a reset, so the first edge after it is skipped
  force_digital_hold_copy_a: assert property ($past(i_nrst) |->
    o_digital_hold_active == $past(i_force_digital_hold))
    else $error("digital hold not mirrored");
  avg_write_a: assert property (i_reg_wr && i_reg_addr == ADDR_HISTORY_AVG_TIME |->
    ##2 o_history_avg_time == $past(i_reg_wdata[7:3], 2)) else $error("averaging not taken");
endmodule

// [verification/testbench.sv]
module testbench
  import clk_out_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys, i_nrst, i_reg_wr, i_reg_rd, i_force_digital_hold, p;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [1:0] i_raw_clock_output;
  logic o_reg_rvalid, o_sleep, o_clock_output_1, o_clock_output_2, o_digital_hold_active;
  logic [4:0] o_history_avg_time;
  out_ctrl_t o_out1_ctrl, o_out2_ctrl;
  offset_ref_t o_offset_alarm_ref_sel, er;
  logic [7:0] m [16];
  logic [7:0] q [$];
  logic [31:0] r;
  int n_errors = 0, n_compared = 0, seed = 91, k;

  clock_output_config_regs u_dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_raw_clock_output(i_raw_clock_output),
    .i_force_digital_hold(i_force_digital_hold), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_sleep(o_sleep), .o_out1_ctrl(o_out1_ctrl),
    .o_out2_ctrl(o_out2_ctrl), .o_clock_output_1(o_clock_output_1),
    .o_clock_output_2(o_clock_output_2), .o_offset_alarm_ref_sel(o_offset_alarm_ref_sel),
    .o_history_avg_time(o_history_avg_time), .o_digital_hold_active(o_digital_hold_active)
  );

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_out(got, exp);
  endtask

  task automatic wrap_up;
    if (q.size() != 0) n_errors++;
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      ADDR_FORMAT_SLEEP: return WMASK_FORMAT_SLEEP;
      ADDR_OFFSET_REF: return WMASK_OFFSET_REF;
      ADDR_STATIC_LEVEL: return WMASK_STATIC_LEVEL;
      ADDR_HISTORY_AVG_TIME: return WMASK_HISTORY_AVG_TIME;
      ADDR_BUF_PD: return WMASK_BUF_PD;
      default: return 8'h00;
    endcase
  endfunction

  // Format is hidden while powered down, since only on/off is defined then
  function automatic logic [7:0] exp_ctrl(input logic [2:0] c, input logic cml, input logic off);
    out_format_t f;
    case (c)
      FMT_CODE_CMOS: f = FMT_CMOS;
      FMT_CODE_LVDS_LOW: f = FMT_LVDS_LOW;
      FMT_CODE_LVPECL: f = FMT_LVPECL;
      FMT_CODE_CML: f = cml ? FMT_CML : FMT_OFF;
      FMT_CODE_LVDS: f = FMT_LVDS;
      default: f = FMT_OFF;
    endcase
    return {3'h0, !off && f != FMT_OFF, off ? 3'h0 : f, off};
  endfunction

  function automatic logic [7:0] view(input out_ctrl_t c);
    return {3'h0, c.buffer_on, c.divider_power_down ? 3'h0 : c.format, c.divider_power_down};
  endfunction

  // One port cycle; strobes are re-driven each call so accesses run back to back
  task automatic cyc(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] wd);
    @(negedge i_clk_sys);
    i_reg_wr = w;
    i_reg_rd = rd;
    i_reg_addr = a;
    i_reg_wdata = wd;
    if (rd) q.push_back(m[a[3:0]]);
    if (w) m[a[3:0]] = (wd & wmask(a)) | (m[a[3:0]] & ~wmask(a));
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic do_reset;
    @(negedge i_clk_sys);
    i_nrst = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    m[6] = RST_FORMAT_SLEEP;
    m[7] = RST_OFFSET_REF;
    m[8] = RST_STATIC_LEVEL;
    m[9] = RST_HISTORY_AVG_TIME;
    m[10] = RST_BUF_PD;
  endtask

  task automatic hold(input logic [7:0] v, input logic e1, input logic e2);
    cyc(1'b1, 1'b0, ADDR_STATIC_LEVEL, v);
    idle(8);
    repeat (4) begin
      idle(1);
      cmp_out({6'h0, o_clock_output_2, o_clock_output_1}, {6'h0, e2, e1});
    end
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // Raw output clocks: output 1 toggles every cycle, output 2 every second
  initial begin
    i_raw_clock_output = 2'h0;
    forever @(negedge i_clk_sys) i_raw_clock_output = i_raw_clock_output + 2'h1;
  end

  // Read data watcher; an answer with no read pending counts as a mismatch
  initial forever @(negedge i_clk_sys) begin
    if (o_reg_rvalid !== 1'b0 && q.size() == 0) cmp_rd({7'h0, o_reg_rvalid}, 8'h00);
    else if (o_reg_rvalid !== 1'b0) cmp_rd(o_reg_rdata, q.pop_front());
  end

  initial begin
    i_nrst = 1'b0;
    {i_reg_wr, i_reg_rd, i_force_digital_hold} = 3'h0;
    {i_reg_addr, i_reg_wdata} = 16'h0000;
    foreach (m[j]) m[j] = 8'h00;
    do_reset;
    for (k = 5; k < 12; k++) cyc(1'b0, 1'b1, 8'(k), 8'h00);
    // Reserved bits hold their reset value under all-ones and all-zeros writes
    for (k = 0; k < 14; k++) begin
      cyc(1'b1, 1'b0, 8'(5 + k % 7), k < 7 ? 8'hff : 8'h00);
      cyc(1'b0, 1'b1, 8'(5 + k % 7), 8'h00);
    end
    // Every format code, crossed with sleep and both power down bits
    for (k = 0; k < 64; k++) begin
      cyc(1'b1, 1'b0, ADDR_FORMAT_SLEEP, {1'b0, k[3], k[2:0], k[2:0] ^ 3'h5});
      cyc(1'b1, 1'b0, ADDR_BUF_PD, {4'h0, k[5], k[4], 2'h0});
      idle(2);
      cmp_out(view(o_out1_ctrl), exp_ctrl(k[2:0] ^ 3'h5, 1'b0, k[3] | k[4]));
      cmp_out(view(o_out2_ctrl), exp_ctrl(k[2:0], 1'b1, k[3] | k[5]));
      cmp_out({7'h0, o_sleep}, {7'h0, k[3]});
    end
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      cyc(1'b1, 1'b0, ADDR_OFFSET_REF, {r[7:3], k[2:0]});
      cyc(1'b1, 1'b0, ADDR_HISTORY_AVG_TIME, r[7:0]);
      idle(2);
      er = k == 0 ? REF_CRYSTAL : k == 1 ? REF_INPUT_1 : k == 2 ? REF_INPUT_2 : REF_NONE;
      cmp_out({6'h0, o_offset_alarm_ref_sel}, {6'h0, er});
      cmp_out({3'h0, o_history_avg_time}, {3'h0, r[7:3]});
    end
    cyc(1'b1, 1'b0, ADDR_FORMAT_SLEEP, RST_FORMAT_SLEEP);
    cyc(1'b1, 1'b0, ADDR_BUF_PD, 8'h00);
    hold(8'h90, 1'b0, 1'b1);
    hold(8'h60, 1'b1, 1'b0);
    // Code 11 is reserved and must leave output 1 toggling
    cyc(1'b1, 1'b0, ADDR_STATIC_LEVEL, 8'hf0);
    idle(8);
    p = o_clock_output_1;
    idle(1);
    cmp_out({7'h0, o_clock_output_1}, {7'h0, ~p});
    // Random traffic, unmapped addresses included, with forced hold toggling
    for (k = 0; k < 300; k++) begin
      r = $random(seed);
      i_force_digital_hold = r[8];
      cyc(r[9], r[10], 8'h05 + {5'h00, r[14:12]}, r[7:0]);
    end
    idle(1);
    cmp_out({7'h0, o_digital_hold_active}, {7'h0, i_force_digital_hold});
    do_reset;
    for (k = 5; k < 12; k++) cyc(1'b0, 1'b1, 8'(k), 8'h00);
    idle(2);
    wrap_up;
  end
endmodule

bind clock_output_config_regs clock_output_config_regs_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_force_digital_hold(i_force_digital_hold),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_sleep(o_sleep),
  .o_out1_ctrl(o_out1_ctrl), .o_out2_ctrl(o_out2_ctrl), .o_clock_output_1(o_clock_output_1),
  .o_history_avg_time(o_history_avg_time), .o_digital_hold_active(o_digital_hold_active)
);
